// file: design/cc_channel.sv
/*
 * one capture/compare channel: register, capture edge logic, compare
 * match and the output unit.
 * assumes capture inputs are already synchronised by the timer core.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cc_timer_map.svh"

module cc_channel
	import cc_timer_pkg::*;
(
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// link to the timer core
	cc_chan_if.chan   ch
);

	// ****************************************************************
	// state
	// ****************************************************************
	cnt_t ccr_q, ccr_d;       // channel register
	logic out_q, out_d;       // output unit level
	logic irq_q, irq_d;       // request pulse
	logic prev_q, prev_d;     // last capture level
	logic lvl;                // selected capture level
	logic hit;                // capture edge seen

	// compare match only on a fresh count
	assign ch.eq  = ch.cnt_upd && (ch.cnt == ccr_q);
	assign ch.ccr = ccr_q;
	assign ch.out = out_q;
	assign ch.irq = irq_q;

	// next values of the channel
	always_comb begin
		ccr_d  = ccr_q;
		out_d  = out_q;
		irq_d  = 1'b0;
		case (ch.cap_src)
			CAP_FIRST:  lvl = ch.cap_first;
			CAP_SECOND: lvl = ch.cap_second;
			CAP_GND:    lvl = 1'b0;
			CAP_VCC:    lvl = 1'b1;
			default:    lvl = 1'b0;
		endcase
		prev_d = lvl;
		case (ch.cap_edge)
			EDGE_RISE: hit = lvl & ~prev_q;
			EDGE_FALL: hit = ~lvl & prev_q;
			EDGE_BOTH: hit = lvl ^ prev_q;
			default:   hit = 1'b0;
		endcase
		if (ch.cap_mode) begin
			if (hit) begin
				ccr_d = ch.cnt;
				irq_d = 1'b1;
			end
		end else begin
			// software loads only in compare mode, capture owns it else
			if (ch.ccr_wr) begin
				ccr_d = ch.ccr_wdata;
			end
			if (ch.eq) begin
				irq_d = 1'b1;
			end
		end
		case (ch.out_mode)
			OUT_BIT:     out_d = ch.out_bit;
			OUT_SET:     out_d = ch.eq ? 1'b1 : out_q;
			OUT_TOG_RST: out_d = ch.eq ? ~out_q : (ch.eq0 ? 1'b0 : out_q);
			OUT_SET_RST: out_d = ch.eq ? 1'b1 : (ch.eq0 ? 1'b0 : out_q);
			OUT_TOG:     out_d = ch.eq ? ~out_q : out_q;
			OUT_RST:     out_d = ch.eq ? 1'b0 : out_q;
			OUT_TOG_SET: out_d = ch.eq ? ~out_q : (ch.eq0 ? 1'b1 : out_q);
			OUT_RST_SET: out_d = ch.eq ? 1'b0 : (ch.eq0 ? 1'b1 : out_q);
			default:     out_d = out_q;
		endcase
	end

	// register the channel
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ccr_q  <= `CCR_RST;
			out_q  <= 1'b0;
			irq_q  <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			ccr_q  <= ccr_d;
			out_q  <= out_d;
			irq_q  <= irq_d;
			prev_q <= prev_d;
		end
	end

endmodule // cc_channel

`default_nettype wire

// file: design/cc_timer_top.sv
/*
 * sixteen bit counter with three capture/compare channels, no software
 * registers: configuration arrives on plain inputs.
 * assumes counter clock sources and capture pins are asynchronous and
 * change at most once per two sys_clk_i periods.
 */
// Operation
// - 16-bit counter plus three capture/compare channels
// - capture, compare, pwm and interval timing
// - request on counter overflow
// - separate request from each channel
// - second instance alt clock is ext pin
// - capture input: first, second, ground, supply
// - channel 0 inputs are two pins
// - channel 2 second input is auxiliary clock
// - each channel drives its own output
// - auxiliary and sub-main clocks come from outside
`timescale 1ns/10ps
`default_nettype none
`include "cc_timer_map.svh"

module cc_timer_top
	import cc_timer_pkg::*;
#(
	// 1 for the second timer instance
	parameter bit SECOND_INSTANCE = 1'b0
) (
	// clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  rstn_i,
	// counter clock sources
	input  wire logic                  ext_clock_i,
	input  wire logic                  aux_clock_i,
	input  wire logic                  sub_main_clock_i,
	input  wire logic                  alt_clock_pin_i,
	// capture pins
	input  wire logic                  chan0_capture_in_first_i,
	input  wire logic                  chan0_capture_in_second_i,
	input  wire logic                  chan1_capture_in_first_i,
	input  wire logic                  chan1_capture_in_second_i,
	input  wire logic                  chan2_capture_in_first_i,
	// counter control
	input  wire clk_src_e              clk_src_i,
	input  wire cnt_mode_e             cnt_mode_i,
	input  wire logic                  cnt_clear_i,
	// channel control
	input  wire logic [`CHAN_N-1:0]    cap_mode_i,
	input  wire cap_src_e              cap_src_i  [`CHAN_N],
	input  wire cap_edge_e             cap_edge_i [`CHAN_N],
	input  wire out_mode_e             out_mode_i [`CHAN_N],
	input  wire logic [`CHAN_N-1:0]    out_bit_i,
	input  wire logic [`CHAN_N-1:0]    ccr_wr_i,
	input  wire cnt_t                  ccr_wdata_i,
	// results
	output logic [`CNT_W-1:0]          counter_o,
	output logic [`CHAN_N-1:0][`CNT_W-1:0] ccr_value_o,
	output logic [`CHAN_N-1:0]         chan_out_o,
	// interrupt requests
	output logic                       ovf_irq_o,
	output logic [`CHAN_N-1:0]         chan_irq_o
);

	// ****************************************************************
	// synchronisers
	// ****************************************************************
	logic [`SYNC_N-1:0] sy1_q;     // first stage, read by sy2_q only
	logic [`SYNC_N-1:0] sy2_q;     // second stage, safe to use
	logic [`SYNC_N-1:0] raw;       // asynchronous inputs

	// second instance reuses the ext pin for alt clock
	assign raw[`SY_EXT] = ext_clock_i;
	// aux and sub-main arrive as pins
	assign raw[`SY_AUX] = aux_clock_i;
	assign raw[`SY_SUB] = sub_main_clock_i;
	assign raw[`SY_ALT] = SECOND_INSTANCE ? ext_clock_i : alt_clock_pin_i;
	// channel 0 has two pins for one signal
	assign raw[`SY_C0A] = chan0_capture_in_first_i;
	assign raw[`SY_C0B] = chan0_capture_in_second_i;
	assign raw[`SY_C1A] = chan1_capture_in_first_i;
	assign raw[`SY_C1B] = chan1_capture_in_second_i;
	assign raw[`SY_C2A] = chan2_capture_in_first_i;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= raw;
			sy2_q <= sy1_q;
		end
	end

	// ****************************************************************
	// counter clock selection
	// ****************************************************************
	logic src_lvl;                 // selected, synchronised source
	logic src_prev_q, src_prev_d;  // last level for edge detect
	logic tick;                    // rising edge of the source

	always_comb begin
		case (clk_src_i)
			SRC_EXT: src_lvl = sy2_q[`SY_EXT];
			SRC_AUX: src_lvl = sy2_q[`SY_AUX];
			SRC_SUB: src_lvl = sy2_q[`SY_SUB];
			SRC_ALT: src_lvl = sy2_q[`SY_ALT];
			default: src_lvl = 1'b0;
		endcase
		src_prev_d = src_lvl;
		// a source switch may give one extra tick; stop the counter first
		tick = src_lvl & ~src_prev_q;
	end

	// ****************************************************************
	// counter
	// ****************************************************************
	cnt_t cnt_q, cnt_d;            // counter
	dir_e dir_q, dir_d;            // up/down direction
	logic upd_q, upd_d;            // counter moved this cycle
	logic ovf_q, ovf_d;            // overflow request pulse
	cnt_t period;                  // channel 0 register, period

	// next counter value
	always_comb begin
		cnt_d = cnt_q;
		dir_d = dir_q;
		upd_d = 1'b0;
		ovf_d = 1'b0;
		if (cnt_clear_i) begin
			// clear wins over a tick in the same cycle
			cnt_d = `CNT_RST;
			dir_d = DIR_UP;
		end else if (tick) begin
			case (cnt_mode_i)
				MODE_UP: begin
					// interval timing to channel 0 value
					if (period != `CNT_RST) begin
						upd_d = 1'b1;
						if (cnt_q >= period) begin
							cnt_d = `CNT_RST;
							ovf_d = 1'b1;
						end else begin
							cnt_d = cnt_q + `CNT_ONE;
						end
					end
				end
				MODE_CONT: begin
					upd_d = 1'b1;
					cnt_d = cnt_q + `CNT_ONE;
					ovf_d = (cnt_q == `CNT_MAX);
				end
				MODE_UPDOWN: begin
					if (period != `CNT_RST) begin
						upd_d = 1'b1;
						case (dir_q)
							DIR_UP: begin
								if (cnt_q >= period) begin
									dir_d = DIR_DOWN;
									cnt_d = cnt_q - `CNT_ONE;
								end else begin
									cnt_d = cnt_q + `CNT_ONE;
								end
							end
							DIR_DOWN: begin
								if (cnt_q <= `CNT_ONE) begin
									cnt_d = `CNT_RST;
									dir_d = DIR_UP;
									ovf_d = (cnt_q == `CNT_ONE);
								end else begin
									cnt_d = cnt_q - `CNT_ONE;
								end
							end
							default: dir_d = DIR_UP;
						endcase
					end
				end
				default: ;
			endcase
		end
	end

	// register the counter
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q      <= `CNT_RST;
			dir_q      <= DIR_UP;
			upd_q      <= 1'b0;
			ovf_q      <= 1'b0;
			src_prev_q <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			dir_q      <= dir_d;
			upd_q      <= upd_d;
			ovf_q      <= ovf_d;
			src_prev_q <= src_prev_d;
		end
	end

	// ****************************************************************
	// channels
	// ****************************************************************
	cc_chan_if ch [`CHAN_N] ();
	logic [`CHAN_N-1:0] second_in;  // second capture input per channel

	// channel 2 captures the auxiliary clock
	assign second_in = {sy2_q[`SY_AUX], sy2_q[`SY_C1B], sy2_q[`SY_C0B]};
	assign period    = ch[0].ccr;

	for (genvar k = 0; k < `CHAN_N; k++) begin : g_chan
		assign ch[k].cnt        = cnt_q;
		assign ch[k].cnt_upd    = upd_q;
		assign ch[k].eq0        = ch[0].eq;
		assign ch[k].cap_first  = sy2_q[`SY_C0A + 2 * k];
		assign ch[k].cap_second = second_in[k];
		assign ch[k].cap_mode   = cap_mode_i[k];
		assign ch[k].cap_src    = cap_src_i[k];
		assign ch[k].cap_edge   = cap_edge_i[k];
		assign ch[k].out_mode   = out_mode_i[k];
		assign ch[k].out_bit    = out_bit_i[k];
		assign ch[k].ccr_wr     = ccr_wr_i[k];
		assign ch[k].ccr_wdata  = ccr_wdata_i;
		assign chan_out_o[k]    = ch[k].out;
		assign chan_irq_o[k]    = ch[k].irq;
		assign ccr_value_o[k]   = ch[k].ccr;

		cc_channel u_chan (
			.sys_clk_i (sys_clk_i),
			.rstn_i    (rstn_i),
			.ch        (ch[k])
		);
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign counter_o = cnt_q;
	assign ovf_irq_o = ovf_q;

endmodule // cc_timer_top

`default_nettype wire

// file: shared/cc_chan_if.sv
/*
 * link between the timer core and one capture/compare channel.
 * assumes all signals live in the sys_clk_i domain.
 */
`timescale 1ns/10ps
`default_nettype none

interface cc_chan_if;
	import cc_timer_pkg::*;

	cnt_t      cnt;        // counter value
	logic      cnt_upd;    // counter took a new value this cycle
	logic      eq0;        // channel 0 match, period event
	logic      cap_first;  // synchronised first capture input
	logic      cap_second; // synchronised second capture input
	logic      cap_mode;   // 1 capture, 0 compare
	cap_src_e  cap_src;    // capture input choice
	cap_edge_e cap_edge;   // capture edge choice
	out_mode_e out_mode;   // output unit mode
	logic      out_bit;    // level for the plain output mode
	logic      ccr_wr;     // load compare value
	cnt_t      ccr_wdata;  // compare value to load
	cnt_t      ccr;        // channel register
	logic      eq;         // compare match, combinational
	logic      out;        // channel output, registered
	logic      irq;        // interrupt request pulse, registered

	modport timer (
		output cnt, cnt_upd, eq0, cap_first, cap_second, cap_mode,
		output cap_src, cap_edge, out_mode, out_bit, ccr_wr, ccr_wdata,
		input  ccr, eq, out, irq
	);
	modport chan (
		input  cnt, cnt_upd, eq0, cap_first, cap_second, cap_mode,
		input  cap_src, cap_edge, out_mode, out_bit, ccr_wr, ccr_wdata,
		output ccr, eq, out, irq
	);

endinterface

`default_nettype wire

// file: shared/cc_timer_map.svh
/*
 * constants of the three channel capture/compare timer: widths, reset
 * values and the number of channels and synchronised inputs.
 * assumes it is included by bare name from the package and design files.
 */
`ifndef CC_TIMER_MAP_SVH
`define CC_TIMER_MAP_SVH

// ****************************************************************
// widths and counts
// ****************************************************************
`define CNT_W        16
`define CHAN_N       3
`define SYNC_N       9

// ****************************************************************
// reset and terminal values
// ****************************************************************
`define CNT_RST      16'h0000
`define CNT_MAX      16'hFFFF
`define CNT_ONE      16'h0001
`define CCR_RST      16'h0000

// ****************************************************************
// positions in the synchroniser vector
// ****************************************************************
`define SY_EXT       0
`define SY_AUX       1
`define SY_SUB       2
`define SY_ALT       3
`define SY_C0A       4
`define SY_C0B       5
`define SY_C1A       6
`define SY_C1B       7
`define SY_C2A       8

`endif

// file: shared/cc_timer_pkg.sv
/*
 * types of the three channel capture/compare timer.
 * assumes cc_timer_map.svh sits on the include path.
 */
`include "cc_timer_map.svh"

package cc_timer_pkg;

	// counter clock source
	typedef enum logic [1:0] {
		SRC_EXT,
		SRC_AUX,
		SRC_SUB,
		SRC_ALT
	} clk_src_e;

	// counting mode
	typedef enum logic [1:0] {
		MODE_STOP,
		MODE_UP,
		MODE_CONT,
		MODE_UPDOWN
	} cnt_mode_e;

	// counting direction state of the up/down mode
	typedef enum logic {
		DIR_UP,
		DIR_DOWN
	} dir_e;

	// capture input choice
	typedef enum logic [1:0] {
		CAP_FIRST,
		CAP_SECOND,
		CAP_GND,
		CAP_VCC
	} cap_src_e;

	// capture edge choice
	typedef enum logic [1:0] {
		EDGE_NONE,
		EDGE_RISE,
		EDGE_FALL,
		EDGE_BOTH
	} cap_edge_e;

	// output unit modes
	typedef enum logic [2:0] {
		OUT_BIT,
		OUT_SET,
		OUT_TOG_RST,
		OUT_SET_RST,
		OUT_TOG,
		OUT_RST,
		OUT_TOG_SET,
		OUT_RST_SET
	} out_mode_e;

	typedef logic [`CNT_W-1:0] cnt_t;

endpackage

// file: sim/cc_timer_asserts.sv
/*
 * port assertions of cc_timer_top.
 * assumes it is bound to the top module and shares its clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cc_timer_map.svh"

module cc_timer_asserts
	import cc_timer_pkg::*;
(
	// clock and reset
	input wire logic                 sys_clk_i,
	input wire logic                 rstn_i,
	// watched inputs
	input wire logic                 chan1_capture_in_first_i,
	input wire cnt_mode_e            cnt_mode_i,
	input wire logic                 cnt_clear_i,
	input wire logic [`CHAN_N-1:0]   cap_mode_i,
	input wire cap_src_e             cap_src_i  [`CHAN_N],
	input wire cap_edge_e            cap_edge_i [`CHAN_N],
	// watched outputs
	input wire logic [`CNT_W-1:0]    counter_o,
	input wire logic [`CHAN_N-1:0][`CNT_W-1:0] ccr_value_o,
	input wire logic                 ovf_irq_o,
	input wire logic [`CHAN_N-1:0]   chan_irq_o
);
	// one domain, so one clock and one reset for all
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	AST_CNT_STEP: assert property (
		$changed(counter_o) |-> counter_o == 16'h0000 ||
		counter_o == $past(counter_o) + 16'h0001 ||
		counter_o == $past(counter_o) - 16'h0001)
		else $error("counter jumped");
	AST_CLEAR: assert property (
		cnt_clear_i |=> counter_o == 16'h0000)
		else $error("clear ignored");
	// stop holds; three cycles cover any internal pipeline
	AST_STOP_HOLD: assert property (
		(cnt_mode_i == MODE_STOP && !cnt_clear_i)[*3] |-> $stable(counter_o))
		else $error("counter moved in stop");
	AST_OVF_ZERO: assert property (
		ovf_irq_o |-> counter_o == 16'h0000)
		else $error("overflow without wrap");
	AST_OVF_PULSE: assert property (
		ovf_irq_o |=> !ovf_irq_o)
		else $error("overflow request too long");
	AST_IRQ_PULSE: assert property (
		chan_irq_o != 3'h0 |=> (chan_irq_o & $past(chan_irq_o)) == 3'h0)
		else $error("channel request too long");
	AST_CMP_IRQ: assert property (
		(!cap_mode_i[1] && !$past(cnt_clear_i) && $changed(counter_o) &&
		counter_o == ccr_value_o[1]) |=> chan_irq_o[1])
		else $error("match without request");
	AST_CAP_RISE: assert property (
		(cap_mode_i[1] && cap_src_i[1] == CAP_FIRST &&
		cap_edge_i[1] == EDGE_RISE && $rose(chan1_capture_in_first_i))
		|-> ##[1:4] chan_irq_o[1])
		else $error("capture request missing");

endmodule // cc_timer_asserts

bind cc_timer_top cc_timer_asserts u_cc_timer_asserts (
	.sys_clk_i               (sys_clk_i),
	.rstn_i                  (rstn_i),
	.chan1_capture_in_first_i(chan1_capture_in_first_i),
	.cnt_mode_i              (cnt_mode_i),
	.cnt_clear_i             (cnt_clear_i),
	.cap_mode_i              (cap_mode_i),
	.cap_src_i               (cap_src_i),
	.cap_edge_i              (cap_edge_i),
	.counter_o               (counter_o),
	.ccr_value_o             (ccr_value_o),
	.ovf_irq_o               (ovf_irq_o),
	.chan_irq_o              (chan_irq_o)
);

`default_nettype wire

// file: sim/tb.sv
/*
 * self-checking bench of cc_timer_top, first and second instance wiring.
 * assumes package, interface, design and checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb
	import cc_timer_pkg::*;
;
	// ****
	// stimulus and results
	// ****
	logic             sys_clk_i   = 1'b0; // 100 MHz
	logic             rstn_i      = 1'b0; // active low reset
	logic [8:0]       pin         = 9'h000; // clocks, then capture pins
	clk_src_e         clk_src_i   = SRC_EXT;
	cnt_mode_e        cnt_mode_i  = MODE_STOP;
	logic             cnt_clear_i = 1'b0;
	logic [2:0]       cap_mode_i  = 3'h0;
	cap_src_e         cap_src_i [3] = '{CAP_FIRST, CAP_FIRST, CAP_FIRST};
	cap_edge_e        cap_edge_i [3] = '{EDGE_RISE, EDGE_RISE, EDGE_RISE};
	out_mode_e        out_mode_i [3] = '{OUT_BIT, OUT_BIT, OUT_BIT};
	logic [2:0]       out_bit_i   = 3'h0;
	logic [2:0]       ccr_wr_i    = 3'h0;
	cnt_t             ccr_wdata_i = 16'h0000;
	logic [15:0]      counter_o;
	logic [15:0]      counter_b;     // second instance counter
	logic [2:0][15:0] ccr_value_o;
	logic [2:0]       chan_out_o;
	logic [2:0]       chan_irq_o;
	logic             ovf_irq_o;
	int               err_count = 0;
	int               total_checks = 0;
	int               irq_seen [3] = '{0, 0, 0}; // pulses per channel
	int               ovf_seen = 0;

	always #5 sys_clk_i = ~sys_clk_i;

	// count one-cycle pulses on the falling edge, clear of update races
	always @(negedge sys_clk_i) begin
		for (int k = 0; k < 3; k++) begin
			irq_seen[k] += (chan_irq_o[k] === 1'b1);
		end
		ovf_seen += (ovf_irq_o === 1'b1);
	end

	cc_timer_top #(.SECOND_INSTANCE(1'b0)) u_cc_timer_top (
		.sys_clk_i                (sys_clk_i),
		.rstn_i                   (rstn_i),
		.ext_clock_i              (pin[0]),
		.aux_clock_i              (pin[1]),
		.sub_main_clock_i         (pin[2]),
		.alt_clock_pin_i          (pin[3]),
		.chan0_capture_in_first_i (pin[4]),
		.chan0_capture_in_second_i(pin[5]),
		.chan1_capture_in_first_i (pin[6]),
		.chan1_capture_in_second_i(pin[7]),
		.chan2_capture_in_first_i (pin[8]),
		.clk_src_i                (clk_src_i),
		.cnt_mode_i               (cnt_mode_i),
		.cnt_clear_i              (cnt_clear_i),
		.cap_mode_i               (cap_mode_i),
		.cap_src_i                (cap_src_i),
		.cap_edge_i               (cap_edge_i),
		.out_mode_i               (out_mode_i),
		.out_bit_i                (out_bit_i),
		.ccr_wr_i                 (ccr_wr_i),
		.ccr_wdata_i              (ccr_wdata_i),
		.counter_o                (counter_o),
		.ccr_value_o              (ccr_value_o),
		.chan_out_o               (chan_out_o),
		.ovf_irq_o                (ovf_irq_o),
		.chan_irq_o               (chan_irq_o)
	);

	// second instance wiring: its alternate clock is the ext pin
	cc_timer_top #(.SECOND_INSTANCE(1'b1)) u_cc_timer_top_b (
		.sys_clk_i                (sys_clk_i),
		.rstn_i                   (rstn_i),
		.ext_clock_i              (pin[0]),
		.aux_clock_i              (pin[1]),
		.sub_main_clock_i         (pin[2]),
		.alt_clock_pin_i          (pin[3]),
		.chan0_capture_in_first_i (pin[4]),
		.chan0_capture_in_second_i(pin[5]),
		.chan1_capture_in_first_i (pin[6]),
		.chan1_capture_in_second_i(pin[7]),
		.chan2_capture_in_first_i (pin[8]),
		.clk_src_i                (clk_src_i),
		.cnt_mode_i               (cnt_mode_i),
		.cnt_clear_i              (cnt_clear_i),
		.cap_mode_i               (cap_mode_i),
		.cap_src_i                (cap_src_i),
		.cap_edge_i               (cap_edge_i),
		.out_mode_i               (out_mode_i),
		.out_bit_i                (out_bit_i),
		.ccr_wr_i                 (ccr_wr_i),
		.ccr_wdata_i              (ccr_wdata_i),
		.counter_o                (counter_b),
		.ccr_value_o              (),
		.chan_out_o               (),
		.ovf_irq_o                (),
		.chan_irq_o               ()
	);

	// ****
	// shared tasks
	// ****
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	// high and low three cycles each, above the two-cycle minimum
	task automatic pulse(input int i);
		pin[i] = 1'b1;
		step(3);
		pin[i] = 1'b0;
		step(3);
	endtask

	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic clear_cnt();
		cnt_clear_i = 1'b1;
		step(1);
		cnt_clear_i = 1'b0;
	endtask

	// ****
	// scenarios
	// ****
	task automatic s_reset();
		chk("reset counter", counter_o, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			chk("reset register", ccr_value_o[k], 16'h0000);
		end
		chk("reset outs", {9'h000, ovf_irq_o, chan_irq_o, chan_out_o},
			16'h0000);
	endtask

	task automatic s_outbit();
		out_bit_i = 3'h5;
		step(2);
		chk("out bit", 16'(chan_out_o), 16'h0005);
		out_bit_i = 3'h2;
		step(2);
		chk("out bit", 16'(chan_out_o), 16'h0002);
		out_bit_i = 3'h0;
		step(2);
	endtask

	// each source counts, the next one in the list does not; the second instance alt counts on the ext pin instead
	task automatic s_sources();
		cnt_mode_i = MODE_CONT;
		clear_cnt();
		for (int s = 0; s < 4; s++) begin
			clk_src_i = clk_src_e'(s);
			step(2);
			pulse((s + 1) % 4);
			chk("second alt", counter_b, 16'(s + (s == 3)));
			pulse(s);
			chk("source count", counter_o, 16'(s + 1));
			chk("second count", counter_b, 16'(s + 1));
		end
	endtask

	task automatic s_overflow();
		int o;
		int c;
		clk_src_i = SRC_EXT;
		ccr_wdata_i = 16'h0003;
		ccr_wr_i = 3'h1;
		cnt_mode_i = MODE_UP;
		clear_cnt();
		ccr_wr_i = 3'h0;
		o = ovf_seen;
		c = irq_seen[0];
		repeat (3) pulse(0);
		chk("up count", counter_o, 16'h0003);
		chk("early wrap", 16'(ovf_seen - o), 16'h0000);
		pulse(0);
		chk("up wrap", counter_o, 16'h0000);
		chk("wrap request", 16'(ovf_seen - o), 16'h0001);
		chk("period request", 16'(irq_seen[0] - c), 16'h0001);
	endtask

	task automatic s_compare();
		int c;
		cnt_mode_i = MODE_CONT;
		ccr_wdata_i = 16'h0002;
		ccr_wr_i = 3'h2;
		out_mode_i[1] = OUT_SET;
		clear_cnt();
		ccr_wr_i = 3'h0;
		c = irq_seen[1];
		pulse(0);
		chk("before match", 16'(chan_out_o), 16'h0000);
		pulse(0);
		chk("match out", 16'(chan_out_o), 16'h0002);
		chk("match request", 16'(irq_seen[1] - c), 16'h0001);
	endtask

	// both inputs of every channel; channel 2 second is the aux clock
	task automatic s_capture();
		int c;
		int n;
		n = 2;
		cap_mode_i = 3'h7;
		for (int ch = 0; ch < 3; ch++) begin
			for (int s = 0; s < 2; s++) begin
				cap_src_i[ch] = cap_src_e'(s);
				pulse(0);
				n++;
				c = irq_seen[ch];
				pulse((ch == 2 && s == 1) ? 1 : 4 + 2 * ch + s);
				chk("capture", ccr_value_o[ch], 16'(n));
				chk("cap request", 16'(irq_seen[ch] - c), 16'h0001);
			end
		end
		cap_src_i[1] = CAP_GND;
		pulse(0);
		c = irq_seen[1];
		cap_src_i[1] = CAP_VCC;
		step(6);
		chk("soft capture", ccr_value_o[1], 16'(n + 1));
		cap_edge_i[1] = EDGE_NONE;
		cap_src_i[1] = CAP_FIRST;
		step(2);
		pulse(6);
		chk("edge none", 16'(irq_seen[1] - c), 16'h0001);
		// both edges: the falling capture lands on the last clock edge of pulse
		cap_edge_i[1] = EDGE_BOTH;
		pulse(6);
		step(1);
		chk("both edges", 16'(irq_seen[1] - c), 16'h0003);
	endtask

	// up/down to the channel 0 value; channel 2 toggles on its match
	task automatic s_updown();
		int o;
		cap_mode_i = 3'h0;
		ccr_wdata_i = 16'h0002;
		ccr_wr_i = 3'h5;
		out_mode_i[2] = OUT_TOG;
		cnt_mode_i = MODE_UPDOWN;
		clear_cnt();
		ccr_wr_i = 3'h0;
		o = ovf_seen;
		pulse(0);
		chk("updown count", counter_o, 16'h0001);
		pulse(0);
		chk("updown count", counter_o, 16'h0002);
		chk("toggle out", 16'(chan_out_o), 16'h0006);
		pulse(0);
		chk("updown count", counter_o, 16'h0001);
		chk("updown early", 16'(ovf_seen - o), 16'h0000);
		pulse(0);
		chk("updown count", counter_o, 16'h0000);
		chk("updown wrap", 16'(ovf_seen - o), 16'h0001);
	endtask

	// ****
	// main sequence and hang guard
	// ****
	initial begin
		step(10);
		s_reset();
		rstn_i = 1'b1;
		step(2);
		s_outbit();
		s_sources();
		s_overflow();
		s_compare();
		s_capture();
		s_updown();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		report_and_stop();
	end

endmodule // tb

`default_nettype wire
